// ### logic/pppoe_phy_policy_pkg.sv
// constants and carrier types for the port policy register bank
`default_nettype none
package pppoe_phy_policy_pkg;
   localparam int NUM_PORTS = 26;
   localparam int ADDR_W = 12;
   // printed register indices; byte address is four times the index
   localparam logic [7:0] IDX_PPPOE_LOW = 8'h98;
   localparam logic [7:0] IDX_PPPOE_HIGH = 8'h99;
   localparam logic [7:0] IDX_MASTER_LOW = 8'h9a;
   localparam logic [7:0] IDX_MASTER_HIGH = 8'h9b;
   localparam logic [7:0] IDX_BYPASS_LOW = 8'h9c;
   localparam logic [7:0] IDX_BYPASS_HIGH = 8'h9d;
   localparam logic [7:0] IDX_DISABLE_LOW = 8'h9e;
   localparam logic [7:0] IDX_DISABLE_HIGH = 8'h9f;
   localparam logic [7:0] IDX_LINK_LOW = 8'hc0;
   localparam logic [7:0] IDX_LINK_HIGH = 8'hc1;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam int MGMT_CROSS_BIT = 10;
   localparam logic [15:0] ETH_PPPOE_DISC = 16'h8863;
   localparam logic [15:0] ETH_PPPOE_SESS = 16'h8864;
   // port configuration bit positions
   localparam int CFG_PAUSE_BIT = 4;
   localparam int CFG_SPEED_BIT = 6;
   localparam int CFG_DUPLEX_BIT = 7;
   localparam int CFG_BP_BIT = 15;
   // phy side registers and fields
   localparam logic [4:0] PHY_CTRL_REG = 5'h00;
   localparam logic [4:0] PHY_STAT_REG = 5'h01;
   localparam int PHY_CTRL_SPEED_BIT = 13;
   localparam int PHY_CTRL_DUPLEX_BIT = 8;
   localparam int PHY_STAT_LINK_BIT = 2;
   localparam int PHY_STAT_SPEED_BIT = 14;
   localparam int PHY_STAT_DUPLEX_BIT = 12;
   localparam int PHY_STAT_PAUSE_BIT = 10;
   localparam int MDIO_HDR_BITS = 46;
   localparam int MDIO_DATA_BIT = 48;
   localparam int MDIO_LAST_BIT = 63;
   // mdc timing
   localparam int CLK_MHZ = 200;
   localparam int MDC_HALF_NS = 200;
   localparam int MDC_HALF_CYC = (MDC_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef struct packed {
      logic valid;
      logic [4:0] port;
      logic [15:0] len_type;
      logic mgmt;
   } egress_req_t;
endpackage : pppoe_phy_policy_pkg
`default_nettype wire

// ### logic/port_pppoe_phy_policy_regs.sv
// per-port pppoe egress, phy mastership and poll bypass register bank
`default_nettype none
module port_pppoe_phy_policy_regs
   import pppoe_phy_policy_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire egress_req_t egress_req,
   output logic egress_done,
   output logic egress_allow,
   input wire logic [NUM_PORTS-1:0][15:0] port_cfg,
   input wire logic [NUM_PORTS-1:0] stp_disabled,
   output logic [NUM_PORTS-1:0] port_enable,
   output logic [NUM_PORTS-1:0] link_up,
   output logic [NUM_PORTS-1:0] speed_100,
   output logic [NUM_PORTS-1:0] full_duplex,
   output logic [NUM_PORTS-1:0] pause_en,
   output logic [NUM_PORTS-1:0] backpressure_en,
   output logic mdc,
   output logic mdio_out,
   output logic mdio_oe_n,
   input wire logic mdio_in
);
   typedef enum logic [2:0] {
      ST_PICK = 3'b001,
      ST_SHIFT = 3'b010,
      ST_NEXT = 3'b100
   } poll_state_t;
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
   endfunction : merge
   function automatic logic is_pppoe(input logic [15:0] len_type);
      is_pppoe = (len_type == ETH_PPPOE_DISC) || (len_type == ETH_PPPOE_SESS);
   endfunction : is_pppoe
   logic [15:0] pppoe_lo_ff, master_lo_ff, bypass_lo_ff, disable_lo_ff;
   logic [10:0] pppoe_hi_ff;
   logic [9:0] master_hi_ff, bypass_hi_ff, disable_hi_ff;
   logic [NUM_PORTS-1:0] pppoe_only, phy_master, bypass, port_dis;
   logic mgmt_cross;
   assign pppoe_only = {pppoe_hi_ff[9:0], pppoe_lo_ff};
   assign mgmt_cross = pppoe_hi_ff[MGMT_CROSS_BIT];
   assign phy_master = {master_hi_ff, master_lo_ff};
   assign bypass = {bypass_hi_ff, bypass_lo_ff};
   assign port_dis = {disable_hi_ff, disable_lo_ff};
   // write channels, taken in either order
   logic awready_ff, wready_ff, aw_held_ff, w_held_ff, bvalid_ff;
   logic [1:0] bresp_ff;
   logic [7:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic do_write;
   assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         waddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            unique case (waddr_ff)
               IDX_PPPOE_LOW, IDX_PPPOE_HIGH, IDX_MASTER_LOW, IDX_MASTER_HIGH,
               IDX_BYPASS_LOW, IDX_BYPASS_HIGH, IDX_DISABLE_LOW, IDX_DISABLE_HIGH,
               IDX_LINK_LOW, IDX_LINK_HIGH: bresp_ff <= RESP_OKAY;
               default: bresp_ff <= RESP_SLVERR;
            endcase
         end
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pppoe_lo_ff <= REG_RESET;
         pppoe_hi_ff <= REG_RESET[10:0];
         master_lo_ff <= REG_RESET;
         master_hi_ff <= REG_RESET[9:0];
         bypass_lo_ff <= REG_RESET;
         bypass_hi_ff <= REG_RESET[9:0];
         disable_lo_ff <= REG_RESET;
         disable_hi_ff <= REG_RESET[9:0];
      end else if (do_write) begin
         unique case (waddr_ff)
            IDX_PPPOE_LOW: pppoe_lo_ff <= merge(pppoe_lo_ff, wdata_ff, wstrb_ff);
            IDX_PPPOE_HIGH: pppoe_hi_ff <= 11'(merge(16'(pppoe_hi_ff), wdata_ff, wstrb_ff));
            IDX_MASTER_LOW: master_lo_ff <= merge(master_lo_ff, wdata_ff, wstrb_ff);
            IDX_MASTER_HIGH: master_hi_ff <= 10'(merge(16'(master_hi_ff), wdata_ff, wstrb_ff));
            IDX_BYPASS_LOW: bypass_lo_ff <= merge(bypass_lo_ff, wdata_ff, wstrb_ff);
            IDX_BYPASS_HIGH: bypass_hi_ff <= 10'(merge(16'(bypass_hi_ff), wdata_ff, wstrb_ff));
            IDX_DISABLE_LOW: disable_lo_ff <= merge(disable_lo_ff, wdata_ff, wstrb_ff);
            IDX_DISABLE_HIGH: disable_hi_ff <= 10'(merge(16'(disable_hi_ff), wdata_ff, wstrb_ff));
            default: ;
         endcase
      end
   end
   // read channel, one cycle after the address is taken
   logic arready_ff, rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rresp_ff <= RESP_OKAY;
         unique case (s_axi_araddr[9:2])
            IDX_PPPOE_LOW: rdata_ff <= {16'h0000, pppoe_lo_ff};
            IDX_PPPOE_HIGH: rdata_ff <= {21'h000000, pppoe_hi_ff};
            IDX_MASTER_LOW: rdata_ff <= {16'h0000, master_lo_ff};
            IDX_MASTER_HIGH: rdata_ff <= {22'h000000, master_hi_ff};
            IDX_BYPASS_LOW: rdata_ff <= {16'h0000, bypass_lo_ff};
            IDX_BYPASS_HIGH: rdata_ff <= {22'h000000, bypass_hi_ff};
            IDX_DISABLE_LOW: rdata_ff <= {16'h0000, disable_lo_ff};
            IDX_DISABLE_HIGH: rdata_ff <= {22'h000000, disable_hi_ff};
            IDX_LINK_LOW: rdata_ff <= {16'h0000, link_up[15:0]};
            IDX_LINK_HIGH: rdata_ff <= {22'h000000, link_up[25:16]};
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end
   // egress admission, answered one cycle after the request
   logic egress_done_ff, egress_allow_ff;
   logic eg_dis, eg_only, eg_ok;
   always_comb begin
      eg_dis = 1'b1;
      eg_only = 1'b0;
      if (egress_req.port < 5'(NUM_PORTS)) begin
         eg_dis = port_dis[egress_req.port];
         eg_only = pppoe_only[egress_req.port];
      end
      // management frames only pass a pppoe port through the cross bit
      eg_ok = egress_req.mgmt ? mgmt_cross : is_pppoe(egress_req.len_type);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         egress_done_ff <= 1'b0;
         egress_allow_ff <= 1'b0;
      end else begin
         egress_done_ff <= egress_req.valid;
         egress_allow_ff <= egress_req.valid && !eg_dis && (!eg_only || eg_ok);
      end
   end
   // mdio synchroniser
   logic mdio_meta_ff, mdio_sync_ff;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mdio_meta_ff <= 1'b1;
         mdio_sync_ff <= 1'b1;
      end else begin
         mdio_meta_ff <= mdio_in;
         mdio_sync_ff <= mdio_meta_ff;
      end
   end
   // polling engine: slave phys get a control write before each status read
   poll_state_t state_ff;
   logic [4:0] port_ff;
   logic wrote_ff, is_wr_ff, mdc_ff, mdio_out_ff, mdio_oe_n_ff;
   logic [63:0] frame_ff, frame_new;
   logic [6:0] bit_ff;
   logic [7:0] div_ff;
   logic [15:0] rd_ff, ctrl_word;
   logic [NUM_PORTS-1:0] pl_link_ff, pl_speed_ff, pl_duplex_ff, pl_pause_ff;
   logic want_wr;
   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[PHY_CTRL_SPEED_BIT] = port_cfg[port_ff][CFG_SPEED_BIT];
      ctrl_word[PHY_CTRL_DUPLEX_BIT] = port_cfg[port_ff][CFG_DUPLEX_BIT];
      want_wr = !phy_master[port_ff] && !wrote_ff;
      frame_new = want_wr ?
         {32'hffff_ffff, 4'h5, port_ff, PHY_CTRL_REG, 2'b10, ctrl_word} :
         {32'hffff_ffff, 4'h6, port_ff, PHY_STAT_REG, 2'b11, 16'hffff};
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_ff <= ST_PICK;
         port_ff <= 5'h00;
         wrote_ff <= 1'b0;
         is_wr_ff <= 1'b0;
         frame_ff <= 64'h0;
         bit_ff <= 7'h00;
         div_ff <= 8'h00;
         mdc_ff <= 1'b0;
         mdio_out_ff <= 1'b1;
         mdio_oe_n_ff <= 1'b1;
         rd_ff <= 16'h0000;
      end else begin
         unique case (state_ff)
            ST_PICK: begin
               if (bypass[port_ff]) begin
                  // no management traffic to a bypassed port
                  port_ff <= (port_ff == 5'(NUM_PORTS - 1)) ? 5'h00 : port_ff + 5'h01;
               end else begin
                  frame_ff <= frame_new;
                  is_wr_ff <= want_wr;
                  mdio_out_ff <= frame_new[63];
                  mdio_oe_n_ff <= 1'b0;
                  bit_ff <= 7'h00;
                  div_ff <= 8'h00;
                  state_ff <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (div_ff == 8'(MDC_HALF_CYC - 1)) begin
                  div_ff <= 8'h00;
                  mdc_ff <= !mdc_ff;
                  if (!mdc_ff) begin
                     // phy drives data before our rising edge
                     if (!is_wr_ff && bit_ff >= 7'(MDIO_DATA_BIT)) begin
                        rd_ff <= {rd_ff[14:0], mdio_sync_ff};
                     end
                  end else if (bit_ff == 7'(MDIO_LAST_BIT)) begin
                     mdio_oe_n_ff <= 1'b1;
                     state_ff <= ST_NEXT;
                  end else begin
                     bit_ff <= bit_ff + 7'h01;
                     frame_ff <= {frame_ff[62:0], 1'b1};
                     mdio_out_ff <= frame_ff[62];
                     mdio_oe_n_ff <= !is_wr_ff && (bit_ff + 7'h01 >= 7'(MDIO_HDR_BITS));
                  end
               end else begin
                  div_ff <= div_ff + 8'h01;
               end
            end
            ST_NEXT: begin
               state_ff <= ST_PICK;
               if (is_wr_ff) begin
                  wrote_ff <= 1'b1;
               end else begin
                  wrote_ff <= 1'b0;
                  port_ff <= (port_ff == 5'(NUM_PORTS - 1)) ? 5'h00 : port_ff + 5'h01;
               end
            end
            default: state_ff <= ST_PICK;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pl_link_ff <= '0;
         pl_speed_ff <= '0;
         pl_duplex_ff <= '0;
         pl_pause_ff <= '0;
      end else if (state_ff == ST_NEXT && !is_wr_ff) begin
         pl_link_ff[port_ff] <= rd_ff[PHY_STAT_LINK_BIT];
         pl_speed_ff[port_ff] <= rd_ff[PHY_STAT_SPEED_BIT];
         pl_duplex_ff[port_ff] <= rd_ff[PHY_STAT_DUPLEX_BIT];
         pl_pause_ff[port_ff] <= rd_ff[PHY_STAT_PAUSE_BIT];
      end
   end
   // resolved port status
   logic [NUM_PORTS-1:0] link_ff, speed_ff, duplex_ff, pause_ff, bp_ff, enable_ff;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         link_ff <= '0;
         speed_ff <= '0;
         duplex_ff <= '0;
         pause_ff <= '0;
         bp_ff <= '0;
         enable_ff <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            enable_ff[p] <= !port_dis[p];
            bp_ff[p] <= port_cfg[p][CFG_BP_BIT];
            if (bypass[p]) begin
               link_ff[p] <= !port_dis[p] && !stp_disabled[p];
               speed_ff[p] <= port_cfg[p][CFG_SPEED_BIT];
               duplex_ff[p] <= port_cfg[p][CFG_DUPLEX_BIT];
               pause_ff[p] <= port_cfg[p][CFG_PAUSE_BIT];
            end else begin
               link_ff[p] <= pl_link_ff[p] && !port_dis[p] && !stp_disabled[p];
               speed_ff[p] <= pl_speed_ff[p];
               duplex_ff[p] <= pl_duplex_ff[p];
               pause_ff[p] <= pl_pause_ff[p];
            end
         end
      end
   end
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign egress_done = egress_done_ff;
   assign egress_allow = egress_allow_ff;
   assign port_enable = enable_ff;
   assign link_up = link_ff;
   assign speed_100 = speed_ff;
   assign full_duplex = duplex_ff;
   assign pause_en = pause_ff;
   assign backpressure_en = bp_ff;
   assign mdc = mdc_ff;
   assign mdio_out = mdio_out_ff;
   assign mdio_oe_n = mdio_oe_n_ff;
endmodule : port_pppoe_phy_policy_regs
`default_nettype wire

// ### tb/mdio_phy_model.sv
// behavioural phy on the management serial bus, answers status reads
`default_nettype none
module mdio_phy_model
   import pppoe_phy_policy_pkg::*;
(
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe_n,
   input wire logic [15:0] status,
   output logic mdio_in,
   output logic [31:0] wr_seen,
   output logic [31:0] rd_seen,
   output logic [15:0] last_wr
);
   timeunit 1ns;
   timeprecision 100ps;
   int ones = 0;
   int pos = 0;
   int n = 0;
   logic [15:0] sh = 16'h0;
   logic [15:0] cur;
   logic [17:0] tx = 18'h0;
   logic pend = 1'h0;
   logic drv = 1'h0;
   logic rd_op = 1'h0;
   initial begin
      wr_seen = '0;
      rd_seen = '0;
      last_wr = '0;
   end
   // released line floats high through the pull-up, never the last value
   assign mdio_in = !mdio_oe_n ? mdio_out : (drv ? tx[17] : 1'h1);
   assign cur = {sh[14:0], mdio_in};
   always @(posedge mdc) begin
      sh <= cur;
      ones <= (!mdio_oe_n && mdio_out) ? ones + 1 : 0;
      if (pos == 0 && !mdio_oe_n && !mdio_out && ones >= 32) pos <= 33;
      else if (pos != 0) pos <= (pos == 63) ? 0 : pos + 1;
      if (pos == 45) begin
         rd_op <= cur[11:10] == 2'h2;
         if (cur[11:10] == 2'h2) begin
            rd_seen[cur[9:5]] <= 1'h1;
            pend <= 1'h1;
            tx <= {2'h2, status};
         end else begin
            wr_seen[cur[9:5]] <= 1'h1;
         end
      end
      if (pos == 63 && !rd_op) last_wr <= cur;
   end
   // answer changes on falling mdc so the sampling edge sees it settled
   always @(negedge mdc) begin
      if (pend) begin
         pend <= 1'h0;
         drv <= 1'h1;
         n <= 0;
      end else if (drv && n == 17) begin
         drv <= 1'h0;
      end else if (drv) begin
         tx <= tx << 1;
         n <= n + 1;
      end
   end
endmodule : mdio_phy_model
`default_nettype wire

// ### tb/port_pppoe_phy_policy_regs_props.sv
// port-level assertions for the policy register bank
`default_nettype none
module policy_regs_props
   import pppoe_phy_policy_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire egress_req_t egress_req,
   input wire logic egress_done,
   input wire logic egress_allow,
   input wire logic [NUM_PORTS-1:0] stp_disabled,
   input wire logic [NUM_PORTS-1:0] port_enable,
   input wire logic [NUM_PORTS-1:0] link_up,
   input wire logic mdc
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic mdc_q_ff;
   logic seen_ff;
   int unsigned half_ff;
   always_ff @(posedge core_clk) begin
      mdc_q_ff <= mdc;
      half_ff <= (mdc != mdc_q_ff) ? 1 : half_ff + 1;
   end
   // first toggle after reset has no full half period behind it
   always_ff @(posedge core_clk) begin
      if (!rst_n) seen_ff <= 1'h0;
      else if (mdc != mdc_q_ff) seen_ff <= 1'h1;
   end
   a_done_follows: assert property (egress_req.valid |=> egress_done)
      else $error("egress answer missing");
   a_bad_port: assert property (egress_req.valid && egress_req.port >= NUM_PORTS
      |=> !egress_allow) else $error("out of range port allowed");
   a_disabled_deny: assert property (egress_req.valid && egress_req.port < NUM_PORTS
      && !port_enable[egress_req.port] ##1 !port_enable[$past(egress_req.port)]
      |-> !egress_allow) else $error("disabled port allowed");
   a_link_gate: assert property ((link_up & ((~port_enable & ~$past(port_enable))
      | (stp_disabled & $past(stp_disabled)))) == '0) else $error("gated link up");
   a_mdc_half: assert property ((mdc != mdc_q_ff) && seen_ff
      |-> half_ff >= MDC_HALF_CYC) else $error("mdc half period short");
   a_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held");
endmodule : policy_regs_props
bind port_pppoe_phy_policy_regs policy_regs_props chk (.core_clk, .rst_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .egress_req, .egress_done, .egress_allow, .stp_disabled,
   .port_enable, .link_up, .mdc);
`default_nettype wire

// ### tb/port_pppoe_phy_policy_regs_tb_top.sv
// self-checking bench for the policy register bank
`default_nettype none
module port_pppoe_phy_policy_regs_tb_top
   import pppoe_phy_policy_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   egress_req_t egress_req = '0;
   logic egress_done, egress_allow, mdc, mdio_out, mdio_oe_n, mdio_in;
   logic [NUM_PORTS-1:0][15:0] port_cfg = '0;
   logic [NUM_PORTS-1:0] stp_disabled = '0;
   logic [NUM_PORTS-1:0] port_enable, link_up, speed_100, full_duplex, pause_en;
   logic [NUM_PORTS-1:0] backpressure_en;
   logic [31:0] wr_seen, rd_seen;
   logic [15:0] last_wr;
   logic [15:0] lts [5] = '{16'h8863, 16'h8864, 16'h0800, 16'h8862, 16'h8865};
   int miscompares = 0;
   int checks = 0;
   always #2.5 core_clk = ~core_clk;
   port_pppoe_phy_policy_regs uut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .egress_req, .egress_done,
      .egress_allow, .port_cfg, .stp_disabled, .port_enable, .link_up, .speed_100,
      .full_duplex, .pause_en, .backpressure_en, .mdc, .mdio_out, .mdio_oe_n, .mdio_in);
   // every polled phy reports link, 100M, full duplex and pause
   mdio_phy_model phy (.mdc, .mdio_out, .mdio_oe_n, .status(16'h5404), .mdio_in, .wr_seen,
      .rd_seen, .last_wr);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] rsp);
      @(posedge core_clk);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // only the watchdog ends a hung wait
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, rsp);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] rsp);
      @(posedge core_clk);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rresp, rsp);
      if (rsp == RESP_OKAY) chk(s_axi_rdata, exp);
   endtask : axi_rd
   task automatic send(input logic [4:0] p, input logic [15:0] lt, input logic m, input logic a);
      @(posedge core_clk);
      egress_req <= '{1'h1, p, lt, m};
      @(posedge core_clk);
      egress_req.valid <= 1'h0;
      #1;
      chk(egress_done, 1'h1);
      chk(egress_allow, a);
   endtask : send
   function automatic logic [31:0] wmask(input logic [7:0] idx);
      case (idx)
         IDX_PPPOE_HIGH: return 32'h7ff;
         IDX_MASTER_HIGH, IDX_BYPASS_HIGH, IDX_DISABLE_HIGH: return 32'h3ff;
         default: return 32'hffff;
      endcase
   endfunction : wmask
   initial begin
      logic [7:0] idx;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'h1;
      for (idx = IDX_PPPOE_LOW; idx <= IDX_DISABLE_HIGH; idx++) begin
         axi_rd(idx, 32'h0, RESP_OKAY);
      end
      // bypass set early so the poll engine only visits ports 0 and 1
      axi_wr(IDX_BYPASS_LOW, 32'hfffc, RESP_OKAY);
      axi_wr(IDX_BYPASS_HIGH, 32'h3ff, RESP_OKAY);
      axi_wr(IDX_MASTER_LOW, 32'h2, RESP_OKAY);
      port_cfg[0] <= 16'h00c0;
      port_cfg[5] <= 16'h80d0;
      repeat (4) @(posedge core_clk);
      chk(link_up[6:5], 2'h3);
      chk({speed_100[5], full_duplex[5], pause_en[5], backpressure_en[5]}, 4'hf);
      chk({speed_100[6], full_duplex[6], pause_en[6], backpressure_en[6]}, 4'h0);
      stp_disabled[7] <= 1'h1;
      axi_wr(IDX_DISABLE_LOW, 32'h110, RESP_OKAY);
      repeat (3) @(posedge core_clk);
      chk({link_up[8:7], port_enable[8], port_enable[4]}, 4'h0);
      send(5'h04, 16'h0800, 1'h0, 1'h0);
      axi_wr(IDX_DISABLE_LOW, 32'h0, RESP_OKAY);
      axi_wr(IDX_PPPOE_LOW, 32'h8, RESP_OKAY);
      axi_wr(IDX_PPPOE_HIGH, 32'h2, RESP_OKAY);
      for (int i = 0; i < 5; i++) send(5'h03, lts[i], 1'h0, i < 2);
      send(5'h11, 16'h8864, 1'h0, 1'h1);
      send(5'h11, 16'h0800, 1'h0, 1'h0);
      send(5'h04, 16'h0800, 1'h0, 1'h1);
      send(5'h04, 16'h88cc, 1'h1, 1'h1);
      send(5'h03, 16'h8863, 1'h1, 1'h0);
      send(5'h1a, 16'h8863, 1'h0, 1'h0);
      axi_wr(IDX_PPPOE_HIGH, 32'h402, RESP_OKAY);
      send(5'h03, 16'h0800, 1'h1, 1'h1);
      send(5'h11, 16'h0800, 1'h1, 1'h1);
      send(5'h03, 16'h0800, 1'h0, 1'h0);
      axi_wr(8'h80, 32'h1, RESP_SLVERR);
      axi_rd(8'h80, 32'h0, RESP_SLVERR);
      repeat (40000) @(posedge core_clk);
      chk({wr_seen[1], rd_seen[1]}, 2'h1);
      chk(last_wr & 16'h2100, 16'h2100);
      chk(wr_seen[0] & rd_seen[0], 1'h1);
      chk((wr_seen | rd_seen) >> 2, 32'h0);
      chk({link_up[1:0], speed_100[0], full_duplex[0], pause_en[0]}, 5'h1f);
      // port 7 held down by spanning tree, the rest polled or forced up
      axi_rd(IDX_LINK_LOW, 32'hff7f, RESP_OKAY);
      axi_rd(IDX_LINK_HIGH, 32'h3ff, RESP_OKAY);
      axi_wr(IDX_DISABLE_LOW, 32'h1, RESP_OKAY);
      repeat (3) @(posedge core_clk);
      chk(link_up[0], 1'h0);
      for (idx = IDX_PPPOE_LOW; idx <= IDX_DISABLE_HIGH; idx++) begin
         axi_wr(idx, 32'hffffffff, RESP_OKAY);
         axi_rd(idx, wmask(idx), RESP_OKAY);
      end
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      end_of_test();
   end
endmodule : port_pppoe_phy_policy_regs_tb_top
`default_nettype wire
